/* File: inc/vic_map.svh */
// Constants of the voltage input code scaler: sizes, range codes, limits
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH

`define VIC_NUM_CH      4
`define VIC_CH_W        2
`define VIC_MV_W        16
`define VIC_CODE_W      16
`define VIC_RANGE_W     3
`define VIC_ARITH_W     40

// Range selections
`define VIC_RNG_OFF     3'h0
`define VIC_RNG_FS_B10  3'h1
`define VIC_RNG_FS_U10  3'h2
`define VIC_RNG_RS_B10  3'h3
`define VIC_RNG_RS_U10  3'h4
`define VIC_RNG_RS_B5   3'h5
`define VIC_RNG_RS_U5   3'h6
`define VIC_RNG_RS_1T5  3'h7
`define VIC_RANGE_RST   3'h1

// Full-scale clamp codes
`define VIC_FS_MAX      16'sh7fff
`define VIC_FS_MIN      16'sh8000
`define VIC_ZERO        16'sh0000
// Reduced-scale saturation codes and the 1..5V offset
`define VIC_OVR_HI      16'sh6d4c
`define VIC_OVR_LO_B    16'sh92b4
`define VIC_OVR_LO_U    16'shfeb4
`define VIC_OVR_HI_15   16'sh6d1d
`define VIC_OVR_LO_15   16'shfea7
`define VIC_OFS_15      16'sh1b00

// Input limits in millivolts
`define VIC_MV_P10      16'sh2710
`define VIC_MV_Z        16'sh0000
`define VIC_MV_P10_12   16'sh2788
`define VIC_MV_N10_13   16'shd86e
`define VIC_MV_N0_13    16'shff7e
`define VIC_MV_P5_06    16'sh13c4
`define VIC_MV_N5_07    16'shec32
`define VIC_MV_N0_07    16'shffba
`define VIC_MV_P0_94    16'sh03ac

// Scale factor numerators and millivolt denominators
`define VIC_MUL_65535   40'h000000ffff
`define VIC_MUL_32767   40'h0000007fff
`define VIC_MUL_27648   40'h0000006c00
`define VIC_MUL_55296   40'h000000d800
`define VIC_DEN_20000   40'h0000004e20
`define VIC_DEN_10000   40'h0000002710
`define VIC_DEN_5000    40'h0000001388
`define VIC_DEN_4000    40'h0000000fa0

`endif

/* File: inc/vic_pkg.sv */
// Types shared by the voltage input code scaler files
package vic_pkg;
  `include "vic_map.svh"

  typedef logic [`VIC_RANGE_W-1:0]        vic_range_t;
  typedef logic signed [`VIC_MV_W-1:0]    vic_mv_t;
  typedef logic signed [`VIC_CODE_W-1:0]  vic_code_t;
  typedef logic [`VIC_CH_W-1:0]           vic_ch_t;

  typedef struct packed {
    vic_ch_t ch;
    vic_mv_t mv;
  } vic_sample_t;

  typedef logic [`VIC_NUM_CH-1:0][`VIC_CODE_W-1:0]  vic_code_arr_t;
  typedef logic [`VIC_NUM_CH-1:0][`VIC_RANGE_W-1:0] vic_range_arr_t;
endpackage

/* File: rtl/vic_scale.sv */
// Combinational conversion of one millivolt sample into a code for one range
`timescale 1ns/10ps
`include "vic_map.svh"
module vic_scale (
  input  wire vic_pkg::vic_range_t i_range,
  input  wire vic_pkg::vic_mv_t    i_mv,
  output vic_pkg::vic_code_t       o_code,
  output logic                     o_sat
);
  import vic_pkg::*;

  // Round half away from zero, matching the printed code tables
  function automatic logic signed [`VIC_ARITH_W-1:0] round_div(
    input logic signed [`VIC_ARITH_W-1:0] num,
    input logic [`VIC_ARITH_W-1:0]        den
  );
    logic [`VIC_ARITH_W-1:0] mag;
    mag = num[`VIC_ARITH_W-1] ? `VIC_ARITH_W'(-num) : `VIC_ARITH_W'(num);
    mag = (mag + (den >> 1)) / den;
    return num[`VIC_ARITH_W-1] ? -$signed(mag) : $signed(mag);
  endfunction

  logic [`VIC_ARITH_W-1:0]        mul;
  logic [`VIC_ARITH_W-1:0]        den;
  vic_code_t                      ofs;
  vic_mv_t                        lo_mv;
  vic_mv_t                        hi_mv;
  vic_code_t                      lo_code;
  vic_code_t                      hi_code;
  logic                           alarm_en;
  logic signed [`VIC_ARITH_W-1:0] prod;
  logic signed [`VIC_ARITH_W-1:0] calc;

  always_comb begin
    mul      = `VIC_MUL_27648;
    den      = `VIC_DEN_10000;
    ofs      = `VIC_ZERO;
    lo_mv    = `VIC_MV_Z;
    hi_mv    = `VIC_MV_Z;
    lo_code  = `VIC_ZERO;
    hi_code  = `VIC_ZERO;
    alarm_en = 1'b0;
    case (i_range)
      `VIC_RNG_FS_B10: begin
        mul = `VIC_MUL_65535; den = `VIC_DEN_20000;
        lo_mv = -`VIC_MV_P10; hi_mv = `VIC_MV_P10;
        lo_code = `VIC_FS_MIN; hi_code = `VIC_FS_MAX;
      end
      `VIC_RNG_FS_U10: begin
        mul = `VIC_MUL_32767; den = `VIC_DEN_10000;
        lo_mv = `VIC_MV_Z; hi_mv = `VIC_MV_P10;
        lo_code = `VIC_ZERO; hi_code = `VIC_FS_MAX;
      end
      `VIC_RNG_RS_B10: begin
        lo_mv = `VIC_MV_N10_13; hi_mv = `VIC_MV_P10_12;
        lo_code = `VIC_OVR_LO_B; hi_code = `VIC_OVR_HI; alarm_en = 1'b1;
      end
      `VIC_RNG_RS_U10: begin
        lo_mv = `VIC_MV_N0_13; hi_mv = `VIC_MV_P10_12;
        lo_code = `VIC_OVR_LO_U; hi_code = `VIC_OVR_HI; alarm_en = 1'b1;
      end
      `VIC_RNG_RS_B5: begin
        mul = `VIC_MUL_55296;
        lo_mv = `VIC_MV_N5_07; hi_mv = `VIC_MV_P5_06;
        lo_code = `VIC_OVR_LO_B; hi_code = `VIC_OVR_HI; alarm_en = 1'b1;
      end
      `VIC_RNG_RS_U5: begin
        den = `VIC_DEN_5000;
        lo_mv = `VIC_MV_N0_07; hi_mv = `VIC_MV_P5_06;
        lo_code = `VIC_OVR_LO_U; hi_code = `VIC_OVR_HI; alarm_en = 1'b1;
      end
      `VIC_RNG_RS_1T5: begin
        den = `VIC_DEN_4000; ofs = `VIC_OFS_15;
        lo_mv = `VIC_MV_P0_94; hi_mv = `VIC_MV_P5_06;
        lo_code = `VIC_OVR_LO_15; hi_code = `VIC_OVR_HI_15; alarm_en = 1'b1;
      end
      default: begin
        mul = `VIC_ARITH_W'h0;
      end
    endcase
  end

  assign prod = `VIC_ARITH_W'(i_mv) * $signed(mul);
  assign calc = round_div(prod, den) - `VIC_ARITH_W'(ofs);

  always_comb begin
    o_code = `VIC_ZERO;
    o_sat  = 1'b0;
    if (i_range == `VIC_RNG_OFF) begin
      o_code = `VIC_ZERO;
    end else if (i_mv > hi_mv) begin
      o_code = hi_code;
      o_sat  = alarm_en;
    end else if (i_mv < lo_mv) begin
      o_code = lo_code;
      o_sat  = alarm_en;
    end else if (calc > `VIC_ARITH_W'(hi_code)) begin
      // Bipolar full-scale end point rounds one past the code range; 1..5V top of band computes up to 28063
      o_code = hi_code;
    end else if (calc < `VIC_ARITH_W'(lo_code)) begin
      o_code = lo_code;
    end else begin
      o_code = `VIC_CODE_W'(calc);
    end
  end
endmodule

/* File: rtl/vic_scaler.sv */
// Multi-channel voltage input code scaler with per-channel range and alarm
// Notes on behaviour
// - Range 0 disables; 1..7 select; 1 default
// - Bipolar full scale clamps 32767/-32768, no alarm
// - Unipolar full scale clamps to 32767 and 0
// - Reduced bipolar 10V computes within -10.13..10.12V
// - Reduced bipolar 10V saturates +/-27980 with alarm
// - Reduced 0..10V saturates 27980/-332 with alarm
// - Bipolar 5V saturates +/-27980 beyond band, alarm
// - 0..5V saturates 27980/-332 beyond band, alarm
// - 1..5V saturates 27933/-345 beyond band, alarm
// - 1..5V code is 6.912 per mV minus 6912
`timescale 1ns/10ps
`include "vic_map.svh"
module vic_scaler (
  input  wire                  i_core_clk,
  input  wire                  i_reset,
  input  wire                  i_ce,
  input  wire vic_pkg::vic_sample_t i_sample,
  input  wire                  i_sample_valid,
  input  wire                  i_range_wr,
  input  wire vic_pkg::vic_ch_t    i_range_ch,
  input  wire vic_pkg::vic_range_t i_range_val,
  output vic_pkg::vic_code_arr_t   o_code,
  output logic [`VIC_NUM_CH-1:0]   o_alarm,
  output logic                     o_update,
  output vic_pkg::vic_ch_t         o_update_ch,
  output vic_pkg::vic_range_arr_t  o_range
);
  import vic_pkg::*;

  vic_range_arr_t range_reg;
  vic_sample_t    stage;
  logic           stage_valid;
  vic_range_t     stage_range;
  vic_code_t      next_code;
  logic           next_sat;

  assign stage_range = range_reg[stage.ch];

  // Range settings; a write to range 0 also blanks that channel below
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int i = 0; i < `VIC_NUM_CH; i++) begin
        range_reg[i] <= `VIC_RANGE_RST;
      end
    end else if (i_ce && i_range_wr) begin
      range_reg[i_range_ch] <= i_range_val;
    end
  end

  assign o_range = range_reg;

  // One stage of input capture keeps the wide divider off the input pins' path
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      stage       <= '0;
      stage_valid <= 1'b0;
    end else if (i_ce) begin
      stage       <= i_sample;
      stage_valid <= i_sample_valid;
    end
  end

  vic_scale u_scale (
    .i_range (stage_range),
    .i_mv    (stage.mv),
    .o_code  (next_code),
    .o_sat   (next_sat)
  );

  // Per-channel result and alarm, refreshed by each sample of that channel
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_code  <= '0;
      o_alarm <= '0;
    end else if (i_ce) begin
      for (int i = 0; i < `VIC_NUM_CH; i++) begin
        if (range_reg[i] == `VIC_RNG_OFF) begin
          o_code[i]  <= `VIC_ZERO;
          o_alarm[i] <= 1'b0;
        end else if (stage_valid && stage.ch == `VIC_CH_W'(i)) begin
          o_code[i]  <= next_code;
          o_alarm[i] <= next_sat;
        end
      end
    end
  end

  // Update strobe; samples of a disabled channel are dropped silently
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_update    <= 1'b0;
      o_update_ch <= '0;
    end else if (i_ce) begin
      o_update    <= stage_valid && (stage_range != `VIC_RNG_OFF);
      o_update_ch <= stage.ch;
    end
  end
endmodule

/* File: verification/vic_scaler_asserts.sv */
// Port checks for the voltage input code scaler
`timescale 1ns/10ps
`include "vic_map.svh"
module vic_scaler_asserts (
  input wire                          i_core_clk,
  input wire                          i_reset,
  input wire                          i_ce,
  input wire vic_pkg::vic_sample_t    i_sample,
  input wire                          i_sample_valid,
  input wire                          i_range_wr,
  input wire vic_pkg::vic_ch_t        i_range_ch,
  input wire vic_pkg::vic_range_t     i_range_val,
  input wire vic_pkg::vic_code_arr_t  o_code,
  input wire [`VIC_NUM_CH-1:0]        o_alarm,
  input wire                          o_update,
  input wire vic_pkg::vic_ch_t        o_update_ch,
  input wire vic_pkg::vic_range_arr_t o_range
);
  import vic_pkg::*;
  vic_code_t  upd_code;
  vic_range_t upd_rng;
  assign upd_code = o_code[o_update_ch];
  assign upd_rng  = o_range[o_update_ch];
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_take(bit on);
    i_ce && i_sample_valid && !i_range_wr && ((o_range[i_sample.ch] != 3'h0) == on);
  endsequence
  upd_latency_a: assert property (
    s_take(1) ##1 i_ce |=> o_update && o_update_ch == $past(i_sample.ch, 2))
    else $error("sample not answered in two cycles");
  off_drop_a: assert property (
    s_take(0) |=> ##1 !(o_update && o_update_ch == $past(i_sample.ch, 2)))
    else $error("disabled channel answered");
  range_write_a: assert property (
    i_ce && i_range_wr |=> o_range[$past(i_range_ch)] == $past(i_range_val))
    else $error("range write lost");
  off_blank_a: assert property (
    i_ce && o_range[3] == `VIC_RNG_OFF |=> o_code[3] == 16'h0000 && !o_alarm[3])
    else $error("disabled channel not blanked");
  fs_quiet_a: assert property (
    o_update && upd_rng inside {3'h1, 3'h2} |-> !o_alarm[o_update_ch])
    else $error("full scale range raised alarm");
  fs_floor_a: assert property (
    o_update && upd_rng == 3'h2 |-> upd_code >= `VIC_ZERO)
    else $error("unipolar code below zero");
  rs_span_a: assert property (
    o_update && upd_rng == 3'h3 |-> upd_code >= `VIC_OVR_LO_B && upd_code <= `VIC_OVR_HI)
    else $error("reduced code out of span");
  sat_code_a: assert property (
    o_update && o_alarm[o_update_ch] |-> upd_code inside {`VIC_OVR_HI, `VIC_OVR_LO_B,
      `VIC_OVR_LO_U, `VIC_OVR_HI_15, `VIC_OVR_LO_15})
    else $error("alarm without saturation code");
  alarm_hold_a: assert property (
    $changed(o_alarm) |-> o_update || o_range != $past(o_range, 2))
    else $error("alarm changed without update");
endmodule
bind vic_scaler vic_scaler_asserts i_chk (.i_core_clk, .i_reset, .i_ce, .i_sample,
  .i_sample_valid, .i_range_wr, .i_range_ch, .i_range_val, .o_code, .o_alarm, .o_update,
  .o_update_ch, .o_range);

/* File: verification/vic_afe_model.sv */
// Behavioural converter front end handing samples to the scaler
`timescale 1ns/10ps
module vic_afe_model (
  input  wire                  i_core_clk,
  output vic_pkg::vic_sample_t o_sample,
  output logic                 o_sample_valid
);
  import vic_pkg::*;
  initial begin
    o_sample       = '0;
    o_sample_valid = 1'b0;
  end
  // Idle bus shows the inverted last value so a stale sample cannot pass
  task automatic put(input vic_ch_t c, input vic_mv_t v);
    @(posedge i_core_clk);
    o_sample       <= '{ch: c, mv: v};
    o_sample_valid <= 1'b1;
    @(posedge i_core_clk);
    o_sample       <= ~o_sample;
    o_sample_valid <= 1'b0;
  endtask
endmodule

/* File: verification/voltage_input_code_scaler_tb_top.sv */
// Self-checking bench for the voltage input code scaler
`timescale 1ns/10ps
`include "vic_map.svh"
module voltage_input_code_scaler_tb_top;
  import vic_pkg::*;
  logic                   i_core_clk = 1'b0;
  logic                   i_reset    = 1'b1;
  logic                   ce         = 1'b1;
  logic                   wr         = 1'b0;
  vic_ch_t                wch        = '0;
  vic_range_t             wval       = 3'h1;
  vic_sample_t            smp;
  logic                   vld;
  vic_code_arr_t          code;
  logic [`VIC_NUM_CH-1:0] alarm;
  logic                   upd;
  vic_ch_t                upd_ch;
  vic_range_arr_t         rng;
  vic_ch_t                ch;
  int                     num_errors   = 0;
  int                     total_checks = 0;
  always #5 i_core_clk = ~i_core_clk;
  vic_afe_model i_afe (.i_core_clk(i_core_clk), .o_sample(smp), .o_sample_valid(vld));
  vic_scaler i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(ce), .i_sample(smp),
    .i_sample_valid(vld), .i_range_wr(wr), .i_range_ch(wch), .i_range_val(wval),
    .o_code(code), .o_alarm(alarm), .o_update(upd), .o_update_ch(upd_ch), .o_range(rng));
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_code(input vic_code_t got, input vic_code_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t code %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic set_range(input vic_range_t r);
    @(posedge i_core_clk);
    wr   <= 1'b1;
    wch  <= ch;
    wval <= r;
    @(posedge i_core_clk);
    wr <= 1'b0;
  endtask
  task automatic cv(input vic_range_t r, input vic_mv_t v, input vic_code_t exp, input logic al);
    int n;
    set_range(r);
    i_afe.put(ch, v);
    for (n = 0; n < 6; n++) begin
      @(posedge i_core_clk);
      #1;
      if (upd === 1'b1 && upd_ch === ch) break;
    end
    if (n == 6) begin
      num_errors++;
      $display("[ERR] %0t no update", $time);
      finish_test();
    end
    chk_code(code[ch], exp);
    chk_flag(alarm[ch], al);
  endtask
  task automatic t_full;
    #1;
    for (int c = 0; c < `VIC_NUM_CH; c++) chk_code(vic_code_t'(rng[c]), 16'sh0001);
    ch = 2'h1;
    cv(3'h1, 16'sh03e8, 16'sh0ccd, 1'b0);
    cv(3'h1, 16'sh2711, `VIC_FS_MAX, 1'b0);
    cv(3'h1, 16'shd8ef, `VIC_FS_MIN, 1'b0);
    cv(3'h2, 16'shfe0c, `VIC_ZERO, 1'b0);
    cv(3'h2, 16'sh2711, `VIC_FS_MAX, 1'b0);
  endtask
  task automatic t_reduced;
    ch = 2'h2;
    cv(3'h3, 16'sh2789, `VIC_OVR_HI, 1'b1);
    cv(3'h3, `VIC_MV_P10_12, `VIC_OVR_HI, 1'b0);
    cv(3'h3, 16'shd86d, `VIC_OVR_LO_B, 1'b1);
    cv(3'h4, 16'shff7d, `VIC_OVR_LO_U, 1'b1);
    cv(3'h5, 16'shec31, `VIC_OVR_LO_B, 1'b1);
    cv(3'h5, 16'shfc18, 16'shea66, 1'b0);
  endtask
  task automatic t_low;
    ch = 2'h0;
    cv(3'h6, 16'shffb9, `VIC_OVR_LO_U, 1'b1);
    cv(3'h6, 16'sh03e8, 16'sh159a, 1'b0);
    cv(3'h7, 16'sh13c5, `VIC_OVR_HI_15, 1'b1);
    cv(3'h7, 16'sh03ab, `VIC_OVR_LO_15, 1'b1);
    cv(3'h7, 16'sh07d0, `VIC_OFS_15, 1'b0);
  endtask
  task automatic t_off;
    ch = 2'h3;
    cv(3'h5, 16'sh13c5, `VIC_OVR_HI, 1'b1);
    // Clock enable low: an in-band sample is ignored, so the alarm stays held
    @(posedge i_core_clk);
    ce <= 1'b0;
    i_afe.put(ch, 16'sh03e8);
    repeat (3) begin
      @(posedge i_core_clk);
      #1;
      chk_flag(upd, 1'b0);
      chk_flag(alarm[3], 1'b1);
    end
    @(posedge i_core_clk);
    ce <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk_code(code[3], `VIC_OVR_HI);
    chk_flag(alarm[3], 1'b1);
    set_range(3'h0);
    i_afe.put(ch, 16'sh03e8);
    repeat (4) begin
      @(posedge i_core_clk);
      #1;
      chk_flag(upd === 1'b1 && upd_ch === ch, 1'b0);
    end
    chk_code(code[3], `VIC_ZERO);
    chk_flag(alarm[3], 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_reset <= 1'b0;
    t_full();
    t_reduced();
    t_low();
    t_off();
    finish_test();
  end
endmodule
